// >>> core/vdt_map.svh
`ifndef VDT_MAP_SVH
`define VDT_MAP_SVH
// register indices; byte address is four times the index
`define VDT_IDX_VLAN_READBACK   16'h180e
`define VDT_IDX_VLAN_PROGRESS   16'h1810
`define VDT_IDX_PMAP_COMMAND    16'h1811
`define VDT_IDX_PMAP_WRITE      16'h1812
`define VDT_IDX_PMAP_READ       16'h1813
`define VDT_IDX_PMAP_PROGRESS   16'h1814
// own control registers for the vlan table side and the policy inputs
`define VDT_IDX_VLAN_COMMAND    16'h1820
`define VDT_IDX_VLAN_WRITE      16'h1821
`define VDT_IDX_ADMIT_OUTSIDER  16'h1822
`define VDT_IDX_EGRESS_KIND     16'h1823
// field positions
`define VDT_MEMBER_P2           17
`define VDT_UNTAG_P2            16
`define VDT_MEMBER_P1           15
`define VDT_UNTAG_P1            14
`define VDT_MEMBER_P0           13
`define VDT_UNTAG_P0            12
`define VDT_VID_MSB             11
`define VDT_READBACK_MSB        17
`define VDT_DIR_BIT             7
`define VDT_INDEX_MSB           5
`define VDT_PRIO_MSB            2
`define VDT_VSEL_BIT            5
`define VDT_VIDX_MSB            3
// reset values
`define VDT_RST_READBACK        18'h00000
`define VDT_RST_PRIO            3'h0
`define VDT_RST_CMD             8'h00
// timing: cycles a table command stays busy; pending lasts one more, done, cycle
`define VDT_CMD_CYCLES          2'h2
`endif

// >>> core/vdt_pkg.sv
package vdt_pkg;
  typedef enum logic [1:0] {
    VDT_IDLE  = 2'b00,
    VDT_BUSY  = 2'b01,
    VDT_DONE  = 2'b11
  } vdt_state_t;
  typedef logic [2:0] vdt_port_mask_t;
endpackage

// >>> core/vdt_table_access.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "vdt_map.svh"
// What this block does
// - read-only 18-bit vlan readback, resets zero
// - member port: admit ingress, join egress domain
// - non-member: drop unless admit-outsider; exclude egress
// - untag bit strips tag toward hybrid egress
// - member/untag pairs at 17/16, 15/14, 13/12
// - vlan id returned in low twelve bits
// - vlan pending flag set during command, self-clears
// - command register write launches priority-map access
// - command bit 7: one reads, zero writes
// - six-bit index selects entry; bit 6 reserved
// - priority table undefined after reset
// - three-bit priority in write and read registers
// - table translates received tos/cs into priority
// - priority-map pending flag, read-only, self-clearing
module vdt_table_access (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [15:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 pkt_valid,
  input  wire logic [5:0]           pkt_tos,
  input  wire logic [11:0]          pkt_vid,
  input  wire logic [1:0]           pkt_port,
  output logic [2:0]                pkt_priority,
  output logic                      pkt_admit,
  output vdt_pkg::vdt_port_mask_t   pkt_egress_mask,
  output vdt_pkg::vdt_port_mask_t   pkt_untag_mask
);
  import vdt_pkg::*;

  // register index decode, shared by read mux and write strobes
  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    return a[15:2] == idx[13:0] && a[1:0] == 2'b00;
  endfunction

  logic [15:0] reg_addr;
  logic        acc;
  logic        wr;
  assign reg_addr = paddr;
  assign acc      = psel && penable && !pready;
  // writes land only at the edge where the master sees pready high
  assign wr       = psel && penable && pready && pwrite;

  // storage
  logic [17:0] vlan_tab [0:15];
  logic [11:0] pvid_tab [0:2];
  logic [2:0]  pmap_tab [0:63];  // no reset: undefined until written
  logic [17:0] vlan_table_readback;
  logic [7:0]  priority_map_command;
  logic [2:0]  priority_map_write_value;
  logic [2:0]  priority_map_read_value;
  logic [5:0]  vlan_table_command;
  logic [17:0] vlan_write_value;
  logic [2:0]  admit_outsider_setting;
  logic [2:0]  egress_port_kind;
  vdt_state_t  vstate;
  vdt_state_t  pstate;
  logic [1:0]  vcnt;
  logic [1:0]  pcnt;
  logic        vdir;

  // decoded strobes
  wire w_pcmd  = wr && hit(reg_addr, `VDT_IDX_PMAP_COMMAND);
  wire w_pwr   = wr && hit(reg_addr, `VDT_IDX_PMAP_WRITE);
  wire w_vcmd  = wr && hit(reg_addr, `VDT_IDX_VLAN_COMMAND);
  wire w_vwr   = wr && hit(reg_addr, `VDT_IDX_VLAN_WRITE);
  wire w_adm   = wr && hit(reg_addr, `VDT_IDX_ADMIT_OUTSIDER);
  wire w_egk   = wr && hit(reg_addr, `VDT_IDX_EGRESS_KIND);
  wire v_pend  = vstate != VDT_IDLE;
  wire p_pend  = pstate != VDT_IDLE;
  wire p_dir   = priority_map_command[`VDT_DIR_BIT];
  wire [5:0] p_idx = priority_map_command[`VDT_INDEX_MSB:0];
  wire v_sel   = vlan_table_command[`VDT_VSEL_BIT];
  wire [3:0] v_idx = vlan_table_command[`VDT_VIDX_MSB:0];

  // read mux; unmapped addresses read zero with pslverr
  logic [31:0] rmux;
  logic        rmap;
  always_comb begin
    rmux = 32'h0;
    rmap = 1'b1;
    if (hit(reg_addr, `VDT_IDX_VLAN_READBACK))
      rmux = {14'h0, vlan_table_readback};
    else if (hit(reg_addr, `VDT_IDX_VLAN_PROGRESS))
      rmux = {31'h0, v_pend};
    else if (hit(reg_addr, `VDT_IDX_PMAP_COMMAND))
      rmux = {24'h0, p_dir, 1'b0, p_idx};
    else if (hit(reg_addr, `VDT_IDX_PMAP_WRITE))
      rmux = {29'h0, priority_map_write_value};
    else if (hit(reg_addr, `VDT_IDX_PMAP_READ))
      rmux = {29'h0, priority_map_read_value};
    else if (hit(reg_addr, `VDT_IDX_PMAP_PROGRESS))
      rmux = {31'h0, p_pend};
    else if (hit(reg_addr, `VDT_IDX_VLAN_COMMAND))
      rmux = {26'h0, vlan_table_command};
    else if (hit(reg_addr, `VDT_IDX_VLAN_WRITE))
      rmux = {14'h0, vlan_write_value};
    else if (hit(reg_addr, `VDT_IDX_ADMIT_OUTSIDER))
      rmux = {29'h0, admit_outsider_setting};
    else if (hit(reg_addr, `VDT_IDX_EGRESS_KIND))
      rmux = {29'h0, egress_port_kind};
    else
      rmap = 1'b0;
  end

  // apb answer: one wait state, ready pulses for one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      prdata  <= (acc && !pwrite) ? rmux : 32'h0;
      pslverr <= acc && !rmap;
    end
  end

  // software writable fields; read-only bits never stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      priority_map_command     <= `VDT_RST_CMD;
      priority_map_write_value <= `VDT_RST_PRIO;
      vlan_table_command       <= 6'h0;
      vdir                     <= 1'b0;
      vlan_write_value         <= 18'h0;
      admit_outsider_setting   <= 3'h0;
      egress_port_kind         <= 3'h0;
    end else begin
      if (w_pcmd)
        priority_map_command <= {pwdata[7], 1'b0, pwdata[5:0]};
      if (w_pwr)
        priority_map_write_value <= pwdata[2:0];
      if (w_vcmd && !v_pend) begin
        vlan_table_command <= pwdata[5:0];
        vdir               <= pwdata[6];
      end
      if (w_vwr)
        vlan_write_value <= pwdata[17:0];
      if (w_adm)
        admit_outsider_setting <= pwdata[2:0];
      if (w_egk)
        egress_port_kind <= pwdata[2:0];
    end
  end

  // priority-map command sequencer; a write to the command launches it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pstate                  <= VDT_IDLE;
      pcnt                    <= 2'h0;
      priority_map_read_value <= `VDT_RST_PRIO;
    end else begin
      case (pstate)
        VDT_IDLE: if (w_pcmd) begin
          pstate <= VDT_BUSY;
          pcnt   <= `VDT_CMD_CYCLES;
        end
        VDT_BUSY: begin
          pcnt <= pcnt - 2'h1;
          if (pcnt == 2'h1)
            pstate <= VDT_DONE;
        end
        VDT_DONE: begin
          if (p_dir)
            priority_map_read_value <= pmap_tab[p_idx];
          pstate <= VDT_IDLE;
        end
        default: pstate <= VDT_IDLE;
      endcase
    end
  end

  // table storage, no reset so contents are undefined until software fills
  always_ff @(posedge mclk) begin
    if (pstate == VDT_DONE && !p_dir)
      pmap_tab[p_idx] <= priority_map_write_value;
    if (vstate == VDT_DONE && vdir) begin
      if (v_sel)
        pvid_tab[v_idx[1:0]] <= vlan_write_value[11:0];
      else
        vlan_tab[v_idx] <= vlan_write_value;
    end
  end

  // vlan command sequencer: bit 6 of command selects write(1)/read(0)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vstate              <= VDT_IDLE;
      vcnt                <= 2'h0;
      vlan_table_readback <= `VDT_RST_READBACK;
    end else begin
      case (vstate)
        VDT_IDLE: if (w_vcmd) begin
          vstate <= VDT_BUSY;
          vcnt   <= `VDT_CMD_CYCLES;
        end
        VDT_BUSY: begin
          vcnt <= vcnt - 2'h1;
          if (vcnt == 2'h1)
            vstate <= VDT_DONE;
        end
        VDT_DONE: begin
          if (!vdir) begin
            if (v_sel)
              vlan_table_readback <= {6'h0, pvid_tab[v_idx[1:0]]};
            else
              vlan_table_readback <= vlan_tab[v_idx];
          end
          vstate <= VDT_IDLE;
        end
        default: vstate <= VDT_IDLE;
      endcase
    end
  end

  // packet path: find the vlan entry whose vid matches
  logic [17:0] ent;
  logic        found;
  always_comb begin
    ent   = 18'h0;
    found = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (!found && vlan_tab[i][`VDT_VID_MSB:0] == pkt_vid
          && pkt_vid != 12'h0) begin
        ent   = vlan_tab[i];
        found = 1'b1;
      end
    end
  end

  // member and untag bits per port, port 0 being the external mii
  wire [2:0] member = {ent[`VDT_MEMBER_P2], ent[`VDT_MEMBER_P1],
                       ent[`VDT_MEMBER_P0]};
  wire [2:0] untag  = {ent[`VDT_UNTAG_P2], ent[`VDT_UNTAG_P1],
                       ent[`VDT_UNTAG_P0]};
  wire [1:0] pport  = (pkt_port > 2'd2) ? 2'd0 : pkt_port;
  wire       in_mem = member[pport];
  wire       admit  = !found || in_mem
                      || admit_outsider_setting[pport];
  wire [2:0] emask  = found ? member : 3'h7;
  wire [2:0] umask  = (found && untag[pport])
                      ? (egress_port_kind & emask) : 3'h0;

  // registered packet decisions
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_priority    <= 3'h0;
      pkt_admit       <= 1'b0;
      pkt_egress_mask <= 3'h0;
      pkt_untag_mask  <= 3'h0;
    end else if (pkt_valid) begin
      pkt_priority    <= pmap_tab[pkt_tos];
      pkt_admit       <= admit;
      pkt_egress_mask <= emask;
      pkt_untag_mask  <= umask;
    end
  end
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  import vdt_pkg::*;
  logic           mclk = 1'b0;
  logic           rst_n = 1'b0;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic [15:0]    paddr = 16'h0;
  logic [31:0]    pwdata = 32'h0;
  logic           pready, pslverr, pkt_admit;
  logic [31:0]    prdata, rd;
  logic           er;
  logic           pkt_valid = 1'b0;
  logic [5:0]     pkt_tos = 6'h0;
  logic [11:0]    pkt_vid = 12'h0;
  logic [1:0]     pkt_port = 2'h0;
  logic [2:0]     pkt_priority;
  vdt_port_mask_t egr, unt;
  int             fail_count = 0;
  int             n_compared = 0;
  logic [5:0]     idx [3] = '{6'h00, 6'h3f, 6'h15};
  logic [2:0]     val [3] = '{3'h7, 3'h5, 3'h2};
  logic [15:0]    regs [6] = '{16'h180e, 16'h1810, 16'h1811, 16'h1812,
                               16'h1813, 16'h1814};
  always #25 mclk = ~mclk;
  vdt_table_access i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pkt_valid(pkt_valid), .pkt_tos(pkt_tos), .pkt_vid(pkt_vid),
    .pkt_port(pkt_port), .pkt_priority(pkt_priority), .pkt_admit(pkt_admit),
    .pkt_egress_mask(egr), .pkt_untag_mask(unt));
  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; an idle edge follows so the next setup is clean
  task automatic apb(input logic wr, input logic [15:0] ix,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {ix[13:0], 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // software waits on the pending flag before trusting results
  task automatic poll(input logic [15:0] ix);
    int n;
    n = 0;
    do begin
      apb(1'b0, ix, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    if (rd[0] !== 1'b0) begin
      fail_count++;
      report_and_stop();
    end
    chk("pending clear", {31'h0, rd[0]}, 32'h0);
  endtask
  // one packet; outputs are registered at the same edge that samples valid
  task automatic pkt(input logic [11:0] v, input logic [1:0] p,
                     input logic [5:0] t);
    pkt_valid <= 1'b1;
    pkt_vid <= v;
    pkt_port <= p;
    pkt_tos <= t;
    @(posedge mclk);
    pkt_valid <= 1'b0;
    #1;
  endtask
  task automatic t_reset();
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'b0, 16'h0, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
  endtask
  task automatic t_pmap();
    foreach (idx[i]) begin
      apb(1'b1, 16'h1812, {29'h1fffffff, val[i]});
      apb(1'b1, 16'h1811, {26'h0, idx[i]} | 32'h40);
      poll(16'h1814);
      apb(1'b1, 16'h1811, {26'h0, idx[i]} | 32'h80);
      poll(16'h1814);
      apb(1'b1, 16'h1813, 32'h0);
      apb(1'b0, 16'h1813, 32'h0);
      chk("prio read", rd, {29'h0, val[i]});
      apb(1'b0, 16'h1811, 32'h0);
      chk("cmd read", rd, {26'h2, idx[i]});
    end
    foreach (idx[i]) begin
      pkt(12'h0, 2'h0, idx[i]);
      chk("pkt prio", {29'h0, pkt_priority}, {29'h0, val[i]});
    end
  endtask
  task automatic t_vlan();
    apb(1'b1, 16'h1823, 32'h7);
    apb(1'b1, 16'h1822, 32'h0);
    apb(1'b1, 16'h1821, 32'h0c005);
    apb(1'b1, 16'h1820, 32'h42);
    poll(16'h1810);
    apb(1'b1, 16'h1820, 32'h02);
    poll(16'h1810);
    apb(1'b1, 16'h180e, 32'hffffffff);
    apb(1'b0, 16'h180e, 32'h0);
    chk("readback", rd, 32'h0c005);
    pkt(12'h5, 2'h1, 6'h0);
    chk("member pkt", {25'h0, pkt_admit, egr, unt}, 32'h52);
    pkt(12'h5, 2'h2, 6'h0);
    chk("outsider", {25'h0, pkt_admit, egr, unt}, 32'h10);
    apb(1'b1, 16'h1822, 32'h4);
    pkt(12'h5, 2'h2, 6'h0);
    chk("admitted", {25'h0, pkt_admit, egr, unt}, 32'h50);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_pmap();
    t_vlan();
    report_and_stop();
  end
endmodule

// >>> test/vdt_table_access_monitor.sv
`timescale 1ns/1ps
// protocol and field checks seen from the register bus pins only
module vdt_table_access_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // read responses, decoded by byte address (index times four)
  wire rd_ok = pready && !pwrite;
  wire acc   = psel && penable;
  a_ready_wait: assert property (acc && !pready |=> pready)
    else $error("ready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside response");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_unmapped_err: assert property (pready && paddr == 16'h0 |-> pslverr)
    else $error("unmapped address not flagged");
  a_readback_rsvd: assert property (rd_ok && paddr == 16'h6038
    |-> prdata[31:18] == 14'h0) else $error("readback upper bits set");
  a_pending_rsvd: assert property (rd_ok && (paddr == 16'h6040
    || paddr == 16'h6050) |-> prdata[31:1] == 31'h0)
    else $error("progress register upper bits set");
  a_cmd_rsvd: assert property (rd_ok && paddr == 16'h6044
    |-> prdata[31:8] == 24'h0 && !prdata[6] && !pslverr)
    else $error("command reserved bits set");
  a_prio_rsvd: assert property (rd_ok && (paddr == 16'h6048
    || paddr == 16'h604c) |-> prdata[31:3] == 29'h0)
    else $error("priority register upper bits set");
endmodule
bind vdt_table_access vdt_table_access_monitor i_mon (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr));
